// File: adc_ctrl_map.svh
// Purpose: offsets, field positions, reset values and timing codes of the converter control
// Assumes: byte-wide register port, source clock on i_ref_clk
// Notes: definitions only
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ==========================================================
// register offsets
`define OFS_INPUT_SELECT 8'h03
`define OFS_RESULT_LOW 8'h04
`define OFS_RESULT_MID 8'h05
`define OFS_RESULT_HIGH 8'h06
`define OFS_POWER_MODE 8'h07
`define OFS_HOLD_CLOCK 8'h08
`define OFS_PRESCALE 8'h09
`define OFS_TRIM 8'h0a

// ==========================================================
// reset values
`define RST_INPUT_SELECT 8'h00
`define RST_POWER_MODE 8'h20
`define RST_HOLD_CLOCK 8'h00
`define RST_PRESCALE 8'h00
`define RST_TRIM 8'he4
`define TRIM_EXPECTED 8'he7

// ==========================================================
// power_mode_rate_control fields
`define BIT_FILTER_RESET 7
`define BIT_SLEEP 6
`define BIT_POWER_OFF 5
`define OSR_MSB 4
`define OSR_LSB 1
`define BIT_REF_SEL 0

// ==========================================================
// result_hold_clock_ratio_control fields
`define DIV_MSB 7
`define DIV_LSB 5
`define BIT_NEG_BUF 4
`define BIT_POS_BUF 3
`define BIT_HOLD 2
`define BIT_DONE 1

// ==========================================================
// prescale and input select fields
`define PRESCALE_MSB 4
`define POS_SEL_MSB 2
`define POS_SEL_LSB 0
`define NEG_SEL_MSB 5
`define NEG_SEL_LSB 3
`define TEMP_SENSOR_SEL 3'h7

// ==========================================================
// clock ratio and oversampling codes
`define PRESCALE_BYPASS 5'h1f
`define DIV_CODE_12 3'h2
`define DIV_LAST_30 5'h1d
`define DIV_LAST_12 5'h0b
`define OSR_CODE_MAX 4'h8
`define OSR_TOP 16'h8000
`define SHIFT_BASE 5'h08
`define FULL_POS 24'h7fffff
`define FULL_NEG 24'h800000

`endif

// File: adc_ctrl_pkg.sv
// Purpose: types shared by the converter control modules
// Assumes: nothing
// Notes: mode decode used by top and by nothing else yet, kept here for reuse
package adc_ctrl_pkg;

  typedef enum logic [1:0] {MODE_POWER_DOWN, MODE_SLEEP, MODE_NORMAL, MODE_RESET} mode_e;

  typedef logic [23:0] result_t;

  // ==========================================================
  // power bit dominates, then sleep, then filter reset
  function automatic mode_e decode_mode(input logic off, input logic sleep, input logic rst);
    mode_e m;
    if (off)
      m = MODE_POWER_DOWN;
    else if (sleep)
      m = MODE_SLEEP;
    else if (rst)
      m = MODE_RESET;
    else
      m = MODE_NORMAL;
    return m;
  endfunction : decode_mode

endpackage : adc_ctrl_pkg

// File: filter_link_if.sv
// Purpose: carrier between the control top, clock divider and decimation filter
// Assumes: all signals on i_ref_clk
// Notes: enables are one-cycle pulses, except mclk_en, held high while the divider runs with prescale bypassed
`timescale 1ns/1ps
interface filter_link_if;
  logic [4:0] prescale;
  logic [2:0] ratio_sel;
  logic div_run;
  logic mclk_en;
  logic adck_en;
  logic run;
  logic clear;
  logic [3:0] osr_code;
  logic mod_bit;
  adc_ctrl_pkg::result_t result;
  logic done;

  modport top_mp (output prescale, ratio_sel, div_run, run, clear, osr_code, mod_bit,
                  input mclk_en, adck_en, result, done);
  modport div_mp (input prescale, ratio_sel, div_run, output mclk_en, adck_en);
  modport flt_mp (input adck_en, run, clear, osr_code, mod_bit, output result, done);
endinterface : filter_link_if

// File: clk_ratio_divider.sv
// Purpose: prescaler and modulator clock divider, as enable pulses
// Assumes: i_ref_clk is the converter source clock
// Notes: counters restart whenever the divider is stopped
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module clk_ratio_divider (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  filter_link_if.div_mp link
);
  logic [5:0] presc_cnt;
  logic [5:0] next_presc_cnt;
  logic [4:0] n_cnt;
  logic [4:0] next_n_cnt;
  logic mclk_en;
  logic next_mclk_en;
  logic adck_en;
  logic next_adck_en;
  logic [5:0] presc_last;
  logic [4:0] n_last;

  // ==========================================================
  // divide by two then by code plus one: last count is 2*code+1
  always_comb
  begin
    presc_last = {1'b0, link.prescale} + {1'b0, link.prescale} + 6'h01;
    n_last = (link.ratio_sel == `DIV_CODE_12) ? `DIV_LAST_12 : `DIV_LAST_30; // [RL6]
    next_presc_cnt = presc_cnt;
    next_n_cnt = n_cnt;
    next_mclk_en = 1'b0;
    next_adck_en = 1'b0;
    if (!link.div_run)
    begin
      next_presc_cnt = 6'h00;
      next_n_cnt = 5'h00;
    end
    else
    begin
      if (link.prescale == `PRESCALE_BYPASS) // [RL12]
      begin
        next_mclk_en = 1'b1;
        next_presc_cnt = 6'h00;
      end
      else if (presc_cnt == presc_last) // [RL12]
      begin
        next_mclk_en = 1'b1;
        next_presc_cnt = 6'h00;
      end
      else
        next_presc_cnt = presc_cnt + 6'h01;
      if (mclk_en)
      begin
        if (n_cnt == n_last) // [RL6] [RL11]
        begin
          next_adck_en = 1'b1;
          next_n_cnt = 5'h00;
        end
        else
          next_n_cnt = n_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      presc_cnt <= 6'h00;
      n_cnt <= 5'h00;
      mclk_en <= 1'b0;
      adck_en <= 1'b0;
    end
    else
    begin
      presc_cnt <= next_presc_cnt;
      n_cnt <= next_n_cnt;
      mclk_en <= next_mclk_en;
      adck_en <= next_adck_en;
    end
  end

  assign link.mclk_en = mclk_en;
  assign link.adck_en = adck_en;

endmodule : clk_ratio_divider

// File: decimation_filter.sv
// Purpose: first-order decimation of the modulator bit stream into 24-bit results
// Assumes: one modulator bit per adck enable
// Notes: single integrator trades noise shaping for size; results are scaled to full range
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module decimation_filter (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  filter_link_if.flt_mp link
);
  logic signed [16:0] acc;
  logic signed [16:0] next_acc;
  logic [14:0] cnt;
  logic [14:0] next_cnt;
  adc_ctrl_pkg::result_t result;
  adc_ctrl_pkg::result_t next_result;
  logic done;
  logic next_done;
  logic [3:0] code;
  logic [14:0] cnt_last;
  logic [4:0] shift;
  logic signed [16:0] step;

  // ==========================================================
  // clamp to full scale
  function automatic adc_ctrl_pkg::result_t saturate(input logic signed [31:0] v);
    adc_ctrl_pkg::result_t r;
    if (v > $signed({8'h00, `FULL_POS}))
      r = `FULL_POS; // [RL21]
    else if (v < $signed({8'hff, `FULL_NEG}))
      r = `FULL_NEG; // [RL21]
    else
      r = v[23:0]; // [RL17]
    return r;
  endfunction : saturate

  always_comb
  begin
    // reserved ratio codes fall back to the smallest ratio
    code = (link.osr_code > `OSR_CODE_MAX) ? `OSR_CODE_MAX : link.osr_code;
    cnt_last = 15'((`OSR_TOP >> code) - 16'h0001); // [RL4]
    shift = `SHIFT_BASE + {1'b0, code};
    step = link.mod_bit ? (acc + 17'sd1) : (acc - 17'sd1);
    next_acc = acc;
    next_cnt = cnt;
    next_result = result;
    next_done = 1'b0;
    if (link.clear) // [RL19]
    begin
      next_acc = 17'sd0;
      next_cnt = 15'h0000;
    end
    else if (link.run && link.adck_en)
    begin
      if (cnt == cnt_last) // [RL11]
      begin
        next_result = saturate(32'(step) <<< shift);
        next_done = 1'b1;
        next_acc = 17'sd0;
        next_cnt = 15'h0000;
      end
      else
      begin
        next_acc = step;
        next_cnt = cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc <= 17'sd0;
      cnt <= 15'h0000;
      result <= 24'h000000;
      done <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      cnt <= next_cnt;
      result <= next_result;
      done <= next_done;
    end
  end

  assign link.result = result;
  assign link.done = done;

endmodule : decimation_filter

// File: adc_ctrl_top.sv
// Purpose: control logic of the 24-bit delta-sigma converter module
// Assumes: byte register port driven from logic on i_ref_clk; modulator bit arrives from
//          the analogue core and is synchronised here
// Notes: analogue enables decode straight from register contents
//
// Behaviour
// RL1: power bit 0 powers up, 1 off
// RL2: power bit 1 forces power-down mode
// RL3: software sets power bit before host sleep
// RL4: oversampling code 0..8 gives 32768 halving to 128
// RL5: reference select: 0 internal, 1 external pins
// RL6: clock divide code 000 by 30, 010 by 12
// RL7: buffer bit 0 bypasses, 1 enables buffer
// RL8: hold keeps result, conversions run, flag still
// RL9: done set by hardware, cleared by software
// RL10: without hold every result overwrites data
// RL11: data rate is clock over N times ratio
// RL12: prescale 11111 passes, else divide 2(code+1)
// RL13: software writes 1110_0111 to trim register
// RL14: mode decoded from power, sleep, reset bits
// RL15: reset pulse starts a fresh filter sequence
// RL16: software clears bits, pulses reset, polls done
// RL17: result is 24-bit two's complement
// RL18: temperature sensor on only when selected, awake
// RL19: reset bit clears filter, aborts, blocks conversion
// RL20: result bytes at 04H, 05H, 06H
// RL21: results saturate at positive and negative full scale
// RL22: simultaneous set and clear leaves flag set
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_ctrl_top (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_mod_bit,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_bandgap_on,
  output logic o_pga_on,
  output logic o_core_on,
  output logic o_filter_on,
  output logic o_temp_sensor_on,
  output logic o_ref_external,
  output logic o_neg_ref_buffer_on,
  output logic o_neg_ref_bypass_on,
  output logic o_pos_ref_buffer_on,
  output logic o_pos_ref_bypass_on,
  output logic o_mod_clk_en,
  output logic o_conversion_done,
  output logic o_trim_mismatch
);
  filter_link_if link ();

  logic [5:0] input_select;
  logic [5:0] next_input_select;
  logic [7:0] power_mode_rate_control;
  logic [7:0] next_power_mode_rate_control;
  logic [7:0] result_hold_clock_ratio_control;
  logic [7:0] next_result_hold_clock_ratio_control;
  logic [4:0] converter_clock_prescale;
  logic [4:0] next_converter_clock_prescale;
  logic [7:0] reserved_trim_setting;
  logic [7:0] next_reserved_trim_setting;
  adc_ctrl_pkg::result_t result_data;
  adc_ctrl_pkg::result_t next_result_data;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic mod_meta;
  logic mod_sync;
  logic wr_hold_clock;
  logic accept_result;
  logic done_flag;
  logic module_power_off;
  logic converter_sleep_select;
  logic filter_reset_control;
  logic result_hold_enable;
  adc_ctrl_pkg::mode_e mode;

  // ==========================================================
  // field views
  assign module_power_off = power_mode_rate_control[`BIT_POWER_OFF];
  assign converter_sleep_select = power_mode_rate_control[`BIT_SLEEP];
  assign filter_reset_control = power_mode_rate_control[`BIT_FILTER_RESET];
  assign result_hold_enable = result_hold_clock_ratio_control[`BIT_HOLD];
  assign done_flag = result_hold_clock_ratio_control[`BIT_DONE];

  // ==========================================================
  // operating mode
  always_comb
  begin
    mode = adc_ctrl_pkg::decode_mode(module_power_off, converter_sleep_select,
                                     filter_reset_control); // [RL2] [RL14]
  end

  // ==========================================================
  // modulator bit synchroniser: first stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mod_meta <= 1'b0;
      mod_sync <= 1'b0;
    end
    else
    begin
      mod_meta <= i_mod_bit;
      mod_sync <= mod_meta;
    end
  end

  // ==========================================================
  // clock chain and filter
  always_comb
  begin
    link.prescale = converter_clock_prescale;
    link.ratio_sel = result_hold_clock_ratio_control[`DIV_MSB:`DIV_LSB];
    link.div_run = (mode != adc_ctrl_pkg::MODE_POWER_DOWN); // [RL1]
    // sleep: core off, filter frozen
    link.run = (mode == adc_ctrl_pkg::MODE_NORMAL); // [RL15]
    link.clear = (mode == adc_ctrl_pkg::MODE_RESET) ||
                 (mode == adc_ctrl_pkg::MODE_POWER_DOWN); // [RL19]
    link.osr_code = power_mode_rate_control[`OSR_MSB:`OSR_LSB];
    link.mod_bit = mod_sync;
  end

  clk_ratio_divider u_divider (
    .i_ref_clk (i_ref_clk),
    .i_arst_n (i_arst_n),
    .link (link.div_mp)
  );

  decimation_filter u_filter (
    .i_ref_clk (i_ref_clk),
    .i_arst_n (i_arst_n),
    .link (link.flt_mp)
  );

  // ==========================================================
  // register writes, done flag and data registers
  always_comb
  begin
    wr_hold_clock = i_reg_wr && (i_reg_addr == `OFS_HOLD_CLOCK);
    accept_result = link.done && !result_hold_enable; // [RL8]
    next_input_select = input_select;
    next_power_mode_rate_control = power_mode_rate_control;
    next_result_hold_clock_ratio_control = result_hold_clock_ratio_control;
    next_converter_clock_prescale = converter_clock_prescale;
    next_reserved_trim_setting = reserved_trim_setting;
    next_result_data = result_data;
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `OFS_INPUT_SELECT: next_input_select = i_reg_wdata[5:0];
        `OFS_POWER_MODE: next_power_mode_rate_control = i_reg_wdata;
        `OFS_PRESCALE: next_converter_clock_prescale = i_reg_wdata[`PRESCALE_MSB:0];
        `OFS_TRIM: next_reserved_trim_setting = i_reg_wdata;
        default:
        begin
        end
      endcase
    end
    if (wr_hold_clock)
    begin
      next_result_hold_clock_ratio_control[7:2] = i_reg_wdata[7:2];
      // only a 0 written clears the flag; a 1 is ignored
      if (!i_reg_wdata[`BIT_DONE])
        next_result_hold_clock_ratio_control[`BIT_DONE] = 1'b0; // [RL9]
    end
    // set after the clear so a finishing conversion wins
    if (accept_result)
    begin
      next_result_hold_clock_ratio_control[`BIT_DONE] = 1'b1; // [RL9] [RL22]
      next_result_data = link.result; // [RL10]
    end
    next_result_hold_clock_ratio_control[0] = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      input_select <= 6'(`RST_INPUT_SELECT);
      power_mode_rate_control <= `RST_POWER_MODE;
      result_hold_clock_ratio_control <= `RST_HOLD_CLOCK;
      converter_clock_prescale <= 5'(`RST_PRESCALE);
      reserved_trim_setting <= `RST_TRIM;
      result_data <= 24'h000000;
    end
    else
    begin
      input_select <= next_input_select;
      power_mode_rate_control <= next_power_mode_rate_control;
      result_hold_clock_ratio_control <= next_result_hold_clock_ratio_control;
      converter_clock_prescale <= next_converter_clock_prescale;
      reserved_trim_setting <= next_reserved_trim_setting;
      result_data <= next_result_data;
    end
  end

  // ==========================================================
  // register reads, one cycle after the strobe
  always_comb
  begin
    next_rvalid = i_reg_rd;
    next_rdata = rdata;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `OFS_INPUT_SELECT: next_rdata = {2'b00, input_select};
        `OFS_RESULT_LOW: next_rdata = result_data[7:0]; // [RL20]
        `OFS_RESULT_MID: next_rdata = result_data[15:8]; // [RL20]
        `OFS_RESULT_HIGH: next_rdata = result_data[23:16]; // [RL20]
        `OFS_POWER_MODE: next_rdata = power_mode_rate_control;
        `OFS_HOLD_CLOCK: next_rdata = result_hold_clock_ratio_control;
        `OFS_PRESCALE: next_rdata = {3'b000, converter_clock_prescale};
        `OFS_TRIM: next_rdata = reserved_trim_setting;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;

  // ==========================================================
  // analogue enables
  always_comb
  begin
    o_bandgap_on = (mode != adc_ctrl_pkg::MODE_POWER_DOWN); // [RL1] [RL14]
    o_pga_on = (mode != adc_ctrl_pkg::MODE_POWER_DOWN); // [RL14]
    o_filter_on = (mode != adc_ctrl_pkg::MODE_POWER_DOWN); // [RL14]
    o_core_on = (mode == adc_ctrl_pkg::MODE_NORMAL) ||
                (mode == adc_ctrl_pkg::MODE_RESET); // [RL14]
    o_temp_sensor_on = o_core_on &&
      ((input_select[`POS_SEL_MSB:`POS_SEL_LSB] == `TEMP_SENSOR_SEL) ||
       (input_select[`NEG_SEL_MSB:`NEG_SEL_LSB] == `TEMP_SENSOR_SEL)); // [RL18]
    o_ref_external = power_mode_rate_control[`BIT_REF_SEL]; // [RL5]
    // buffers and their bypasses both drop in power-down and sleep
    o_neg_ref_buffer_on = o_core_on && result_hold_clock_ratio_control[`BIT_NEG_BUF]; // [RL7]
    o_neg_ref_bypass_on = o_core_on && !result_hold_clock_ratio_control[`BIT_NEG_BUF]; // [RL7]
    o_pos_ref_buffer_on = o_core_on && result_hold_clock_ratio_control[`BIT_POS_BUF]; // [RL7]
    o_pos_ref_bypass_on = o_core_on && !result_hold_clock_ratio_control[`BIT_POS_BUF]; // [RL7]
  end

  assign o_mod_clk_en = link.adck_en;
  assign o_conversion_done = done_flag;
  // trim value is never checked by hardware, only flagged
  assign o_trim_mismatch = (reserved_trim_setting != `TRIM_EXPECTED);

endmodule : adc_ctrl_top

// File: adc_ctrl_checker.sv
// Purpose: concurrent checks on the converter control top ports
// Assumes: register writes are one-cycle strobes on i_ref_clk
// Notes: register shadows rebuilt from the write port
`timescale 1ns/1ps
module adc_ctrl_checker (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_bandgap_on,
  input wire logic o_core_on,
  input wire logic o_filter_on,
  input wire logic o_temp_sensor_on,
  input wire logic o_ref_external,
  input wire logic o_neg_ref_buffer_on,
  input wire logic o_neg_ref_bypass_on,
  input wire logic o_conversion_done,
  input wire logic o_trim_mismatch
);
  // ==========================================================
  // shadow registers
  logic [7:0] ctl, next_ctl, trim, next_trim;
  logic hold, next_hold;

  always_comb
  begin
    next_ctl = ctl;
    next_trim = trim;
    next_hold = hold;
    if (i_reg_wr && i_reg_addr == 8'h07)
      next_ctl = i_reg_wdata;
    if (i_reg_wr && i_reg_addr == 8'h0a)
      next_trim = i_reg_wdata;
    if (i_reg_wr && i_reg_addr == 8'h08)
      next_hold = i_reg_wdata[2];
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctl <= 8'h20;
      trim <= 8'he4;
      hold <= 1'b0;
    end
    else
    begin
      ctl <= next_ctl;
      trim <= next_trim;
      hold <= next_hold;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  chk_power_off_gate: assert property (o_filter_on == !ctl[5]
    && o_bandgap_on == !ctl[5])
    else $error("filter or bandgap enable disagrees with power bit");
  chk_core_mode: assert property (o_core_on == (!ctl[5] && !ctl[6]))
    else $error("core enable disagrees with mode bits");
  chk_ref_pair: assert property (o_ref_external == ctl[0])
    else $error("reference pair output disagrees with select bit");
  chk_temp_awake: assert property (o_temp_sensor_on |-> o_core_on)
    else $error("temperature sensor on while core is off");
  chk_buffer_bypass: assert property (o_core_on
    |-> o_neg_ref_buffer_on != o_neg_ref_bypass_on)
    else $error("negative buffer and bypass not exclusive");
  chk_done_sticky: assert property (o_conversion_done
    && !(i_reg_wr && i_reg_addr == 8'h08 && !i_reg_wdata[1]) |=> o_conversion_done)
    else $error("done flag dropped without a software clear");
  chk_hold_no_done: assert property (hold && !o_conversion_done |=> !o_conversion_done)
    else $error("done flag rose while results are held");
  chk_trim_flag: assert property (o_trim_mismatch == (trim != 8'he7))
    else $error("trim mismatch flag wrong");
  chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 8'h0a
    |=> o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_done_readback: assert property (i_reg_rd && i_reg_addr == 8'h08
    |=> o_reg_rdata[1] == $past(o_conversion_done) && !o_reg_rdata[0])
    else $error("done bit readback wrong");

  cover property ($rose(o_conversion_done));
  cover property (o_filter_on && !o_core_on);
  cover property (hold && o_core_on);
endmodule : adc_ctrl_checker

// File: sigma_delta_adc_control_bench.sv
// Purpose: self-checking bench for the converter control top
// Assumes: inputs change on the falling clock edge, one access at a time
// Notes: shortest ratio, a result every 1536 clocks, keeps the run short
`timescale 1ns/1ps
module sigma_delta_adc_control_bench;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;
    logic [10:0] outs;} row_s;
  logic i_ref_clk, i_arst_n, i_reg_wr, i_reg_rd, i_mod_bit;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd_val;
  logic o_reg_rvalid, o_bandgap_on, o_pga_on, o_core_on, o_filter_on, o_temp_sensor_on;
  logic o_ref_external, o_neg_ref_buffer_on, o_neg_ref_bypass_on, o_pos_ref_buffer_on;
  logic o_pos_ref_bypass_on, o_mod_clk_en, o_conversion_done, o_trim_mismatch, ok;
  logic [10:0] outs;
  logic [15:0] gap;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] rst_addr [5] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h03};
  logic [7:0] rst_val [5] = '{8'h20, 8'h00, 8'h00, 8'he4, 8'h00};
  // prescale, divide register, expected enable spacing
  logic [31:0] gaps [6] = '{{8'h1f, 8'h00, 16'd30}, {8'h1f, 8'h40, 16'd12},
    {8'h1f, 8'h20, 16'd30}, {8'h00, 8'h40, 16'd24}, {8'h02, 8'h00, 16'd180},
    {8'h1e, 8'h40, 16'd744}};
  logic [23:0] osr [2] = '{{8'h0e, 16'd3072}, {8'h10, 16'd1536}};
  row_s rows [17] = '{'{8'h0a, 8'he7, 8'he7, 11'h000}, '{8'h07, 8'h21, 8'h21, 11'h020},
    '{8'h07, 8'he0, 8'he0, 11'h000}, '{8'h07, 8'h40, 8'h40, 11'h680},
    '{8'h03, 8'h3f, 8'h3f, 11'h680}, '{8'h08, 8'h18, 8'h18, 11'h680},
    '{8'h07, 8'h80, 8'h80, 11'h7d4}, '{8'h08, 8'h08, 8'h08, 11'h7cc},
    '{8'h03, 8'h07, 8'h07, 11'h7cc}, '{8'h03, 8'h38, 8'h38, 11'h7cc},
    '{8'h03, 8'h36, 8'h36, 11'h78c}, '{8'h08, 8'h03, 8'h00, 11'h78a},
    '{8'h09, 8'hff, 8'h1f, 11'h78a}, '{8'h04, 8'h55, 8'h00, 11'h78a},
    '{8'h30, 8'haa, 8'h00, 11'h78a}, '{8'h0a, 8'he4, 8'he4, 11'h78b},
    '{8'h07, 8'h00, 8'h00, 11'h78b}};

  assign outs = {o_bandgap_on, o_pga_on, o_core_on, o_filter_on, o_temp_sensor_on,
    o_ref_external, o_neg_ref_buffer_on, o_neg_ref_bypass_on, o_pos_ref_buffer_on,
    o_pos_ref_bypass_on, o_trim_mismatch};

  adc_ctrl_top uut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_mod_bit(i_mod_bit), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_bandgap_on(o_bandgap_on), .o_pga_on(o_pga_on), .o_core_on(o_core_on),
    .o_filter_on(o_filter_on), .o_temp_sensor_on(o_temp_sensor_on),
    .o_ref_external(o_ref_external), .o_neg_ref_buffer_on(o_neg_ref_buffer_on),
    .o_neg_ref_bypass_on(o_neg_ref_bypass_on), .o_pos_ref_buffer_on(o_pos_ref_buffer_on),
    .o_pos_ref_bypass_on(o_pos_ref_bypass_on), .o_mod_clk_en(o_mod_clk_en),
    .o_conversion_done(o_conversion_done), .o_trim_mismatch(o_trim_mismatch));

  // ==========================================================
  // reporting
  task automatic end_sim;
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic tally(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : tally

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tally({16'h0000, got}, {16'h0000, exp});
  endtask : chk_byte

  task automatic chk_outs(input logic [10:0] got, input logic [10:0] exp);
    tally({13'h0000, got}, {13'h0000, exp});
  endtask : chk_outs

  task automatic chk_gap(input logic [15:0] got, input logic [15:0] exp);
    tally({8'h00, got}, {8'h00, exp});
  endtask : chk_gap

  // ==========================================================
  // register port and waits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_ref_clk);
    i_reg_rd = 1'b0;
    d = o_reg_rvalid ? o_reg_rdata : 8'hxx;
  endtask : rd

  task automatic res_chk(input logic [23:0] exp);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'h04 + 8'(i), rd_val);
      chk_byte(rd_val, exp[8*i +: 8]);
    end
  endtask : res_chk

  task automatic wait_done(input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge i_ref_clk);
      hit = (o_conversion_done === 1'b1);
    end
  endtask : wait_done

  task automatic measure(output logic [15:0] n);
    n = 16'h0000;
    repeat (2)
    begin
      @(negedge i_ref_clk);
      for (int i = 0; i < 2000 && o_mod_clk_en !== 1'b1; i++)
        @(negedge i_ref_clk);
    end
    do
    begin
      @(negedge i_ref_clk);
      n++;
    end while (o_mod_clk_en !== 1'b1 && n < 16'd2000);
  endtask : measure

  // first done only aligns to the result stream; the second gives the period
  task automatic period(output logic [15:0] n);
    int t0;
    wr(8'h08, 8'h40);
    wait_done(4000, ok);
    t0 = cyc;
    wr(8'h08, 8'h40);
    wait_done(4000, ok);
    n = 16'(cyc - t0);
  endtask : period

  // ==========================================================
  // clock, timeout, sequence
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    i_arst_n = 1'b0;
    {i_reg_wr, i_reg_rd, i_mod_bit, i_reg_addr, i_reg_wdata} = '0;
    repeat (4) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    chk_outs(outs, 11'h001);
    foreach (rst_addr[i])
    begin
      rd(rst_addr[i], rd_val);
      chk_byte(rd_val, rst_val[i]);
    end
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rd_val);
      chk_byte(rd_val, rows[i].rexp);
      chk_outs(outs, rows[i].outs);
    end
    foreach (gaps[i])
    begin
      wr(8'h09, gaps[i][31:24]);
      wr(8'h08, gaps[i][23:16]);
      measure(gap);
      chk_gap(gap, gaps[i][15:0]);
    end
    i_mod_bit = 1'b1;
    wr(8'h09, 8'h1f);
    foreach (osr[i])
    begin
      wr(8'h07, osr[i][23:16] | 8'h80);
      wr(8'h07, osr[i][23:16]);
      period(gap);
      chk_gap(gap, osr[i][15:0]);
    end
    res_chk(24'h7fffff);
    i_mod_bit = 1'b0;
    period(gap);
    res_chk(24'h800000);
    wr(8'h08, 8'h44);
    i_mod_bit = 1'b1;
    wait_done(3200, ok);
    chk_byte({7'h00, ok}, 8'h00);
    res_chk(24'h800000);
    wr(8'h08, 8'h40);
    wait_done(2000, ok);
    chk_byte({7'h00, ok}, 8'h01);
    res_chk(24'h7fffff);
    wr(8'h07, 8'h90);
    wr(8'h08, 8'h40);
    wait_done(2000, ok);
    chk_byte({7'h00, ok}, 8'h00);
    wr(8'h07, 8'h50);
    wait_done(2000, ok);
    chk_byte({7'h00, ok}, 8'h00);
    wr(8'h07, 8'h10);
    wait_done(2000, ok);
    chk_byte({7'h00, ok}, 8'h01);
    end_sim();
  end
endmodule : sigma_delta_adc_control_bench

bind adc_ctrl_top adc_ctrl_checker chk (.*);
